// ==== rtl/vasd_pkg.sv ====
// constants, modes and carrier types of the vector add/sub datapath
// assumes a single clock with clock enable; no register bus
package vasd_pkg;

    // ****************************************
    // operation, precision, rounding and overflow modes
    // ****************************************
    typedef enum logic [1:0] {
        OP_ADD = 2'h0,
        OP_SUB = 2'h1,
        OP_SEL = 2'h2
    } vasd_op_t;

    typedef enum logic {
        PREC_FULL = 1'h0,
        PREC_USER = 1'h1
    } vasd_prec_t;

    typedef enum logic {
        QUANT_TRUNC = 1'h0,
        QUANT_ROUND = 1'h1
    } vasd_quant_t;

    typedef enum logic {
        OVF_WRAP = 1'h0,
        OVF_SAT = 1'h1
    } vasd_ovf_t;

    // ****************************************
    // defaults and structure limits
    // ****************************************
    localparam int CORE_MAX_LAT = 3;
    localparam int DEF_LANES = 4;
    localparam int DEF_A_W = 16;
    localparam int DEF_A_BP = 8;
    localparam int DEF_B_W = 16;
    localparam int DEF_B_BP = 8;
    localparam int DEF_O_W = 16;
    localparam int DEF_O_BP = 8;
    localparam int DEF_LATENCY = 1;
    localparam int DEF_EXP_W = 8;
    localparam int DEF_FRAC_W = 23;

    // per-sample control that rides along the pipeline
    typedef struct packed {
        logic valid;
        logic sub;
    } vasd_tag_t;

endpackage

// ==== rtl/vasd_skid_buf.sv ====
// two-entry output buffer with valid/ready on both sides
// assumes the filler only pushes while in_ready is high
module vasd_skid_buf #(
    parameter int WIDTH = 8
) (
    input wire logic clk,                  // core clock
    input wire logic rst_n,                // synchronous reset, active low
    input wire logic in_valid,             // push request
    output logic in_ready,                 // room for one more word
    input wire logic [WIDTH-1:0] in_data,  // pushed word
    output logic out_valid,                // head word valid
    input wire logic out_ready,            // receiver takes head
    output logic [WIDTH-1:0] out_data      // head word
);

    logic [WIDTH-1:0] spare;
    logic spare_valid;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire head_free = ~out_valid | pop;
    // head is refilled from spare first so order is kept
    wire next_spare_valid = head_free ? (spare_valid & push) : (spare_valid | push);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            spare_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            spare_valid <= next_spare_valid;
            in_ready <= ~next_spare_valid;
            if (head_free) begin
                out_valid <= spare_valid | push;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (head_free) begin
            out_data <= spare_valid ? spare : in_data;
        end
        if (push && (spare_valid || !head_free)) begin
            spare <= in_data;
        end
    end

endmodule

// ==== rtl/vasd_top.sv ====
// vector adder/subtracter datapath, LANES elements per sample period
// assumes upstream and downstream logic on CORE_CLK with clock enable CE
// Summary of operation
// - all lanes computed every sample period
// - fixed add, fixed subtract, or selectable
// - select high subtracts, low adds
// - carry-in only user precision, integer inputs
// - carry-out only unsigned, matching integer width
// - latency in sample periods, output register chain
// - unpipelined: one core register, rest after
// - pipelined: stages inside core, excess after
// - full precision fixed-point sum is exact
// - user format, signedness, quantize, overflow
// - floating point: full precision, float core
module vasd_top #(
    parameter int LANES = vasd_pkg::DEF_LANES,
    parameter vasd_pkg::vasd_op_t OP_MODE = vasd_pkg::OP_SEL,
    parameter int A_W = vasd_pkg::DEF_A_W,
    parameter int A_BP = vasd_pkg::DEF_A_BP,
    parameter bit A_SIGNED = 1'b1,
    parameter int B_W = vasd_pkg::DEF_B_W,
    parameter int B_BP = vasd_pkg::DEF_B_BP,
    parameter bit B_SIGNED = 1'b1,
    parameter vasd_pkg::vasd_prec_t PRECISION = vasd_pkg::PREC_FULL,
    parameter int O_W = vasd_pkg::DEF_O_W,
    parameter int O_BP = vasd_pkg::DEF_O_BP,
    parameter bit O_SIGNED = 1'b1,
    parameter vasd_pkg::vasd_quant_t QUANT = vasd_pkg::QUANT_TRUNC,
    parameter vasd_pkg::vasd_ovf_t OVF = vasd_pkg::OVF_WRAP,
    parameter bit CIN_EN = 1'b0,
    parameter bit COUT_EN = 1'b0,
    parameter int LATENCY = vasd_pkg::DEF_LATENCY,
    parameter bit PIPELINE = 1'b0,
    parameter bit FLOAT_OPS = 1'b0,
    parameter int EXP_W = vasd_pkg::DEF_EXP_W,
    parameter int FRAC_W = vasd_pkg::DEF_FRAC_W,
    localparam int AI = A_W - A_BP,
    localparam int BI = B_W - B_BP,
    localparam int MI = (AI > BI) ? AI : BI,
    localparam int FF = (A_BP > B_BP) ? A_BP : B_BP,
    localparam int SIA = AI + (A_SIGNED ? 0 : 1),
    localparam int SIB = BI + (B_SIGNED ? 0 : 1),
    localparam int FX_W = ((SIA > SIB) ? SIA : SIB) + 1 + FF,
    localparam int FP_W = 1 + EXP_W + FRAC_W,
    localparam int W = FLOAT_OPS ? FP_W : FX_W,
    localparam bit USER = !FLOAT_OPS && (PRECISION == vasd_pkg::PREC_USER),
    localparam int OUT_W = FLOAT_OPS ? FP_W : (USER ? O_W : FX_W)
) (
    input wire logic CORE_CLK,                    // core clock
    input wire logic RST_N,                       // synchronous reset, active low
    input wire logic CE,                          // clock enable, one sample period
    input wire logic IN_VALID,                    // operand vectors valid
    output logic IN_READY,                        // operands taken when valid, ready, CE
    input wire logic [LANES*A_W-1:0] A_VEC,       // operand a, lane 0 lowest
    input wire logic [LANES*B_W-1:0] B_VEC,       // operand b, lane 0 lowest
    input wire logic SUB_SEL,                     // subtract when high, selectable mode
    input wire logic [LANES-1:0] CARRY_IN,        // per-lane carry in
    output logic OUT_VALID,                       // result vector valid
    input wire logic OUT_READY,                   // receiver takes result
    output logic [LANES*OUT_W-1:0] SUM_VEC,       // result, lane 0 lowest
    output logic [LANES-1:0] CARRY_OUT            // per-lane carry out
);

    // ****************************************
    // configuration
    // ****************************************
    localparam bit HAS_CIN = CIN_EN && USER && (A_BP == 0) && (B_BP == 0);
    localparam bit HAS_COUT = COUT_EN && USER && !A_SIGNED && !B_SIGNED && !O_SIGNED
        && ((O_W - O_BP) == MI);
    localparam int CORE_LIM = (LATENCY < vasd_pkg::CORE_MAX_LAT) ? LATENCY
        : vasd_pkg::CORE_MAX_LAT;
    localparam int CORE = PIPELINE ? CORE_LIM : ((LATENCY > 0) ? 1 : 0);
    localparam int POST = LATENCY - CORE;
    localparam int TW = ((W + O_BP > O_W) ? W + O_BP : O_W) + 2;
    localparam logic signed [TW-1:0] ONE = TW'(1);
    localparam logic signed [TW-1:0] HALF = (ONE <<< FF) >>> 1;
    localparam logic signed [TW-1:0] MAXV = O_SIGNED ? (ONE <<< (O_W - 1)) - ONE
        : (ONE <<< O_W) - ONE;
    localparam logic signed [TW-1:0] MINV = O_SIGNED ? -(ONE <<< (O_W - 1)) : '0;

    // ****************************************
    // float adder: truncating, subnormals flushed
    // ****************************************
    function automatic logic [FP_W-1:0] fp_add(input logic [FP_W-1:0] x,
                                               input logic [FP_W-1:0] y,
                                               input logic neg);
        logic [FP_W-1:0] big;
        logic [FP_W-1:0] sml;
        logic [EXP_W-1:0] eb;
        logic [EXP_W-1:0] es;
        logic [FRAC_W+3:0] mb;
        logic [FRAC_W+3:0] ms;
        logic [EXP_W-1:0] sh;
        big = x;
        sml = {y[FP_W-1] ^ neg, y[FP_W-2:0]};
        if (sml[FP_W-2:0] > big[FP_W-2:0]) begin
            big = sml;
            sml = x;
            sml[FP_W-1] = sml[FP_W-1] ^ neg;
        end
        eb = big[FP_W-2:FRAC_W];
        es = sml[FP_W-2:FRAC_W];
        mb = {1'b0, eb != '0, big[FRAC_W-1:0], 2'h0};
        ms = {1'b0, es != '0, sml[FRAC_W-1:0], 2'h0};
        sh = eb - es;
        ms = (32'(sh) > FRAC_W + 3) ? '0 : ms >> sh;
        mb = (big[FP_W-1] == sml[FP_W-1]) ? mb + ms : mb - ms;
        if (mb[FRAC_W+3]) begin
            mb = mb >> 1;
            eb = eb + EXP_W'(1);
        end
        for (int i = 0; i < FRAC_W + 2; i++) begin
            if (!mb[FRAC_W+2] && mb != '0 && eb > EXP_W'(1)) begin
                mb = mb << 1;
                eb = eb - EXP_W'(1);
            end
        end
        // infinities and NaN inputs are not special-cased
        if (!mb[FRAC_W+2] || eb == '0) begin
            return {big[FP_W-1], {(FP_W-1){1'b0}}};
        end else if (eb == '1) begin
            return {big[FP_W-1], {EXP_W{1'b1}}, {FRAC_W{1'b0}}};
        end
        return {big[FP_W-1], eb, mb[FRAC_W+1:2]};
    endfunction

    // ****************************************
    // flow control
    // ****************************************
    logic buf_ready;
    // whole pipe holds still while the buffer is full: no word is lost
    wire adv = CE & buf_ready;
    wire in_sub = (OP_MODE == vasd_pkg::OP_SUB) ? 1'b1
        : (OP_MODE == vasd_pkg::OP_SEL) ? SUB_SEL : 1'b0;

    vasd_pkg::vasd_tag_t t0, t1, t2, t3;
    logic [LANES-1:0][W-1:0] a0, b0, a1, b1, s1, s2;
    logic [LANES-1:0] c0, c1, co1, co2, co3;
    logic [LANES-1:0][OUT_W-1:0] q2, q3;

    assign t0 = '{valid: IN_VALID, sub: in_sub};
    assign c0 = HAS_CIN ? CARRY_IN : '0;

    // ****************************************
    // per-lane arithmetic
    // ****************************************
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        wire [A_W-1:0] a_raw = A_VEC[l*A_W +: A_W];
        wire [B_W-1:0] b_raw = B_VEC[l*B_W +: B_W];
        wire [W-1:0] a_ext = A_SIGNED ? W'($signed(a_raw)) : W'(a_raw);
        wire [W-1:0] b_ext = B_SIGNED ? W'($signed(b_raw)) : W'(b_raw);
        // binary points aligned so the sum is exact
        assign a0[l] = FLOAT_OPS ? a_ext : a_ext << (FF - A_BP);
        assign b0[l] = FLOAT_OPS ? b_ext : b_ext << (FF - B_BP);
        wire [W-1:0] b_op = t1.sub ? -b1[l] : b1[l];
        wire [W-1:0] fx_sum = a1[l] + b_op + W'(c1[l]);
        assign s1[l] = FLOAT_OPS ? W'(fp_add(FP_W'(a1[l]), FP_W'(b1[l]), t1.sub)) : fx_sum;
        assign co1[l] = HAS_COUT ? fx_sum[FF + MI] : 1'b0;

        logic signed [TW-1:0] t;
        always_comb begin
            t = TW'($signed(s2[l]));
            t = t <<< O_BP;
            if (QUANT == vasd_pkg::QUANT_ROUND) begin
                t = t + (t[TW-1] ? HALF - ONE : HALF);
            end
            t = t >>> FF;
            if (OVF == vasd_pkg::OVF_SAT) begin
                if (t > MAXV) begin
                    t = MAXV;
                end else if (t < MINV) begin
                    t = MINV;
                end
            end
        end
        assign q2[l] = USER ? OUT_W'(t) : OUT_W'(s2[l]);
    end

    // ****************************************
    // core registers
    // ****************************************
    if (CORE >= 2) begin : g_r1
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                t1 <= '0;
            end else if (adv) begin
                t1 <= t0;
            end
        end
        always_ff @(posedge CORE_CLK) begin
            if (adv) begin
                a1 <= a0;
                b1 <= b0;
                c1 <= c0;
            end
        end
    end else begin : g_n1
        assign t1 = t0;
        assign a1 = a0;
        assign b1 = b0;
        assign c1 = c0;
    end

    if (CORE >= 3) begin : g_r2
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                t2 <= '0;
            end else if (adv) begin
                t2 <= t1;
            end
        end
        always_ff @(posedge CORE_CLK) begin
            if (adv) begin
                s2 <= s1;
                co2 <= co1;
            end
        end
    end else begin : g_n2
        assign t2 = t1;
        assign s2 = s1;
        assign co2 = co1;
    end

    if (CORE >= 1) begin : g_r3
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                t3 <= '0;
            end else if (adv) begin
                t3 <= t2;
            end
        end
        always_ff @(posedge CORE_CLK) begin
            if (adv) begin
                q3 <= q2;
                co3 <= co2;
            end
        end
    end else begin : g_n3
        assign t3 = t2;
        assign q3 = q2;
        assign co3 = co2;
    end

    // ****************************************
    // output delay chain
    // ****************************************
    logic [POST:0] pv;
    logic [POST:0][LANES*OUT_W+LANES-1:0] pd;
    assign pv[0] = t3.valid;
    assign pd[0] = {co3, q3};
    for (genvar k = 0; k < POST; k++) begin : g_post
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                pv[k+1] <= 1'b0;
            end else if (adv) begin
                pv[k+1] <= pv[k];
            end
        end
        always_ff @(posedge CORE_CLK) begin
            if (adv) begin
                pd[k+1] <= pd[k];
            end
        end
    end

    // ****************************************
    // output buffer
    // ****************************************
    vasd_skid_buf #(
        .WIDTH(LANES*OUT_W+LANES)
    ) u_buf (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_valid(pv[POST] & CE),
        .in_ready(buf_ready),
        .in_data(pd[POST]),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data({CARRY_OUT, SUM_VEC})
    );
    assign IN_READY = buf_ready;

endmodule

// ==== test/vasd_sink.sv ====
// receiver model on the result side of the datapath
// assumes it is clocked by the core clock
module vasd_sink (
    input wire logic clk, // core clock
    input wire logic [6:0] stall, // stall chance, percent
    output logic ready // takes the head word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ready = 1'b0;
    // ready may drop while a word waits: the design must hold it
    always @(posedge clk) begin
        ready <= ($urandom % 100) >= stall;
    end
endmodule

// ==== test/vasd_chk_asserts.sv ====
// port assertions for the vector add/sub datapath top
// assumes LATENCY 2; lane sums checked for full precision, equal signed formats
module vasd_chk #(
    parameter int LANES = 4,
    parameter int A_W = 16,
    parameter int B_W = 16,
    parameter int OUT_W = 17,
    parameter vasd_pkg::vasd_op_t OP_MODE = vasd_pkg::OP_SEL,
    parameter vasd_pkg::vasd_prec_t PRECISION = vasd_pkg::PREC_FULL,
    parameter bit COUT_EN = 1'b0
) (
    input wire logic CORE_CLK, // clock
    input wire logic RST_N, // reset
    input wire logic CE, // enable
    input wire logic IN_VALID, // valid in
    input wire logic IN_READY, // room
    input wire logic [LANES*A_W-1:0] A_VEC, // a
    input wire logic [LANES*B_W-1:0] B_VEC, // b
    input wire logic SUB_SEL, // select
    input wire logic [LANES-1:0] CARRY_IN, // carry in
    input wire logic OUT_VALID, // valid out
    input wire logic OUT_READY, // taken
    input wire logic [LANES*OUT_W-1:0] SUM_VEC, // result
    input wire logic [LANES-1:0] CARRY_OUT // carry out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic take;
    logic pop;
    logic sub;
    logic [3:0] pend;
    logic [3:0] next_pend;
    logic [LANES*OUT_W-1:0] want;
    assign take = IN_VALID && IN_READY && CE;
    assign pop = OUT_VALID && OUT_READY;
    assign sub = (OP_MODE == vasd_pkg::OP_SEL) ? SUB_SEL : (OP_MODE == vasd_pkg::OP_SUB);
    assign next_pend = pend + 4'(take) - 4'(pop);
    always_ff @(posedge CORE_CLK) begin
        pend <= RST_N ? next_pend : 4'h0;
    end
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [A_W:0] x;
        logic [B_W:0] y;
        assign x = {A_VEC[l*A_W+A_W-1], A_VEC[l*A_W+:A_W]};
        assign y = {B_VEC[l*B_W+B_W-1], B_VEC[l*B_W+:B_W]};
        assign want[l*OUT_W+:OUT_W] = OUT_W'(sub ? x - y : x + y);
    end
    // ****************
    // assertions
    // ****************
    default clocking dcb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    // receiver ready throughout: up to three words ahead are gone, the head is this word
    sequence s_flow;
        take && OUT_READY ##1 (CE && OUT_READY) [*2];
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) !RST_N |=> !OUT_VALID && IN_READY)
        else $error("outputs not idle after reset");
    a_result_due: assert property (s_flow |=> OUT_VALID)
        else $error("result late");
    a_lane_sum: assert property (s_flow |=>
        PRECISION != vasd_pkg::PREC_FULL || SUM_VEC == $past(want, 3))
        else $error("lane result wrong");
    a_out_hold: assert property (OUT_VALID && !OUT_READY |=>
        OUT_VALID && $stable(SUM_VEC) && $stable(CARRY_OUT))
        else $error("stalled result changed");
    a_carry_quiet: assert property (OUT_VALID |-> COUT_EN || CARRY_OUT == '0)
        else $error("carry out without its conditions");
    a_no_orphan: assert property (OUT_VALID |-> pend != 4'h0)
        else $error("result without operands");
    a_last_gone: assert property (pop && pend == 4'h1 |=> !OUT_VALID)
        else $error("extra result");
    a_room_back: assert property (pop && !IN_READY |-> ##[1:2] IN_READY)
        else $error("room not restored");
    c_sub: cover property (take && sub);
    c_stall: cover property (OUT_VALID && !OUT_READY ##1 !IN_READY);
    c_flow: cover property (s_flow);
    c_carry: cover property (OUT_VALID && CARRY_OUT != '0);
endmodule

bind vasd_top vasd_chk #(
    .LANES(LANES), .A_W(A_W), .B_W(B_W), .OUT_W(OUT_W), .OP_MODE(OP_MODE),
    .PRECISION(PRECISION), .COUT_EN(COUT_EN)
) i_chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
    .A_VEC(A_VEC), .B_VEC(B_VEC), .SUB_SEL(SUB_SEL), .CARRY_IN(CARRY_IN),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .SUM_VEC(SUM_VEC), .CARRY_OUT(CARRY_OUT)
);

// ==== test/tb.sv ====
// bench: select, add, subtract and two user-format instances in lockstep
// assumes default operand formats unless overridden here, receiver model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // full precision width for equal signed formats
    localparam int OW = vasd_pkg::DEF_A_W + 1;
    // rounded and saturated user format
    localparam int RW = 12;
    localparam int RBP = 4;
    typedef logic [4*OW-1:0] vasd_vec_t;
    localparam logic [63:0] CA = 64'h7FFF_8000_FFFF_0001;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic in_valid = 1'b0;
    logic sub_sel = 1'b0;
    logic [63:0] a_vec = 64'h0;
    logic [63:0] b_vec = 64'h0;
    logic [3:0] cin = 4'h0;
    logic out_ready;
    logic [4:0] in_ready;
    logic [4:0] out_valid;
    vasd_vec_t sum [3];
    logic [63:0] sum_u;
    logic [3:0] cout_u;
    logic [4*RW-1:0] sum_r;
    logic [132:0] e;
    logic [132:0] q [$];
    int stall = 0;
    int ce_off = 0;
    int fail_count = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    always @(posedge clk) ce <= ($urandom % 100) >= ce_off;
    for (genvar g = 0; g < 3; g++) begin : g_d
        vasd_top #(.OP_MODE(vasd_pkg::vasd_op_t'(g == 0 ? 2 : g - 1)), .LATENCY(2)) i_dut (
            .CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .IN_VALID(in_valid),
            .IN_READY(in_ready[g]), .A_VEC(a_vec), .B_VEC(b_vec), .SUB_SEL(sub_sel),
            .CARRY_IN(cin), .OUT_VALID(out_valid[g]), .OUT_READY(out_ready),
            .SUM_VEC(sum[g]), .CARRY_OUT());
    end
    // unsigned integer format with carries, pipelined core
    if (1) begin : g_u
        vasd_top #(
            .OP_MODE(vasd_pkg::OP_ADD), .A_BP(0), .A_SIGNED(1'b0), .B_BP(0), .B_SIGNED(1'b0),
            .PRECISION(vasd_pkg::PREC_USER), .O_BP(0), .O_SIGNED(1'b0), .CIN_EN(1'b1),
            .COUT_EN(1'b1), .LATENCY(2), .PIPELINE(1'b1)
        ) i_dut (
            .CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .IN_VALID(in_valid),
            .IN_READY(in_ready[3]), .A_VEC(a_vec), .B_VEC(b_vec), .SUB_SEL(sub_sel),
            .CARRY_IN(cin), .OUT_VALID(out_valid[3]), .OUT_READY(out_ready),
            .SUM_VEC(sum_u), .CARRY_OUT(cout_u));
    end
    // signed narrow format, rounded and saturated
    if (1) begin : g_r
        vasd_top #(
            .PRECISION(vasd_pkg::PREC_USER), .O_W(RW), .O_BP(RBP),
            .QUANT(vasd_pkg::QUANT_ROUND), .OVF(vasd_pkg::OVF_SAT), .LATENCY(2)
        ) i_dut (
            .CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .IN_VALID(in_valid),
            .IN_READY(in_ready[4]), .A_VEC(a_vec), .B_VEC(b_vec), .SUB_SEL(sub_sel),
            .CARRY_IN(cin), .OUT_VALID(out_valid[4]), .OUT_READY(out_ready),
            .SUM_VEC(sum_r), .CARRY_OUT());
    end
    vasd_sink i_sink (.clk(clk), .stall(7'(stall)), .ready(out_ready));
    function automatic vasd_vec_t expv(logic [63:0] a, logic [63:0] b, logic s);
        vasd_vec_t r;
        logic [OW-1:0] x;
        logic [OW-1:0] y;
        for (int l = 0; l < 4; l++) begin
            x = {a[l*16+15], a[l*16+:16]};
            y = {b[l*16+15], b[l*16+:16]};
            r[l*OW+:OW] = s ? x - y : x + y;
        end
        return r;
    endfunction
    // 16-bit lane sums with carry in; carries packed above the four sums
    function automatic vasd_vec_t expu(logic [63:0] a, logic [63:0] b, logic [3:0] c);
        vasd_vec_t r;
        logic [16:0] s;
        r = '0;
        for (int l = 0; l < 4; l++) begin
            s = 17'(a[l*16+:16]) + 17'(b[l*16+:16]) + 17'(c[l]);
            r[l*16+:16] = s[15:0];
            r[64+l] = s[16];
        end
        return r;
    endfunction
    // exact sum has 8 fraction bits: round half away from zero, then clamp
    function automatic logic [4*RW-1:0] expr(logic [63:0] a, logic [63:0] b, logic s);
        logic [4*RW-1:0] r;
        int m;
        int v;
        for (int l = 0; l < 4; l++) begin
            m = s ? int'($signed(a[l*16+:16])) - int'($signed(b[l*16+:16]))
                : int'($signed(a[l*16+:16])) + int'($signed(b[l*16+:16]));
            v = ((m < 0 ? -m : m) + (1 << (7 - RBP))) >> (8 - RBP);
            v = m < 0 ? -v : v;
            v = v > (1 << (RW - 1)) - 1 ? (1 << (RW - 1)) - 1 : v;
            v = v < -(1 << (RW - 1)) ? -(1 << (RW - 1)) : v;
            r[l*RW+:RW] = RW'(v);
        end
        return r;
    endfunction
    task automatic check(vasd_vec_t got, vasd_vec_t exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // holds the request until the edge that takes it
    task automatic push(logic [63:0] a, logic [63:0] b, logic s);
        int n = 0;
        in_valid <= 1'b1;
        a_vec <= a;
        b_vec <= b;
        sub_sel <= s;
        cin <= 4'($urandom);
        do begin
            @(posedge clk);
            n++;
        end while (!(in_ready[0] && ce) && n < 500);
    endtask
    task automatic rnd(int n);
        repeat (n)
            push({$urandom, $urandom}, {$urandom, $urandom}, 1'($urandom));
    endtask
    task automatic finish_test(string name);
        in_valid <= 1'b0;
        stall <= 0;
        ce_off <= 0;
        repeat (30) @(posedge clk);
        check(vasd_vec_t'(q.size()), vasd_vec_t'(8'h00));
        $display("test %s done", name);
    endtask
    always @(posedge clk) begin
        if (rst_n && in_valid && in_ready[0] && ce)
            q.push_back({cin, sub_sel, a_vec, b_vec});
        if (rst_n && out_valid[0] && out_ready) begin
            check(vasd_vec_t'(q.size() > 0), vasd_vec_t'(1'h1));
            e = q.pop_front();
            check(vasd_vec_t'(out_valid), vasd_vec_t'(5'h1F));
            for (int g = 0; g < 3; g++)
                check(sum[g], expv(e[127:64], e[63:0], g == 0 ? e[128] : g == 2));
            check({cout_u, sum_u}, expu(e[127:64], e[63:0], e[132:129]));
            check(vasd_vec_t'(sum_r), vasd_vec_t'(expr(e[127:64], e[63:0], e[128])));
        end
    end
    // tests take about 1100 cycles; a stuck handshake ends here
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("MISMATCH at %0t: run timed out", $time);
        tally_and_finish();
    end
    initial begin
        void'($urandom(4));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            push(CA, 64'({CA, CA} >> (16 * (i % 4))), i > 3);
        finish_test("corner operands");
        rnd(200);
        finish_test("random back to back");
        stall <= 50;
        ce_off <= 30;
        rnd(300);
        finish_test("random with stalls");
        stall <= 100;
        push(CA, ~CA, 1'b1);
        push(~CA, CA, 1'b0);
        repeat (12) @(posedge clk);
        check(vasd_vec_t'({in_ready, out_valid}), vasd_vec_t'(10'h01F));
        finish_test("buffer fill and drain");
        rnd(5);
        rst_n <= 1'b0;
        in_valid <= 1'b0;
        repeat (2) @(posedge clk);
        check(vasd_vec_t'({in_ready, out_valid}), vasd_vec_t'(10'h3E0));
        q.delete();
        rst_n <= 1'b1;
        @(posedge clk);
        rnd(60);
        finish_test("reset in mid run");
        tally_and_finish();
    end
endmodule
